// ### design/zsvs_top.sv
/*
  Zero-sequence voltage supervision with input-configuration handling
  and metering of derived voltages.
  Assumes phasor samples from the measurement front end, synchronous
  to i_ref_clk, and settings held steady by the configuring party.
*/
// Operation
// - Alarm when residual magnitude above 10 V long enough
// - Detection time 1.0 to 100.0 s, 0.1 s steps
// - Use setting off means never alarm
// - Zero-sequence from phase sum or neutral input
// - Delta means phase-phase inputs, star phase-neutral
// - Delta two-voltage mode calculates metered C-A from others, residual sums the raw C-A input
// - Star derives line voltages from phase voltages
// - Star ignores the three-or-two voltage selection
// - Delta shows no phase-neutral values in metering
`timescale 1ns/10ps
`include "zsvs_params.svh"
module zsvs_top #(
  parameter int STEP_CYC = `ZSVS_STEP_CYC
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Settings
  input wire zsvs_pkg::zsvs_cfg_t i_cfg,
  input wire logic [9:0] i_residual_detect_time,
  // Samples
  input wire logic i_sample_valid,
  input wire zsvs_pkg::zsvs_chan_t i_chan,
  input wire zsvs_pkg::zsvs_phasor_t i_neutral_voltage_input,
  // Results
  output logic o_alarm,
  output logic o_timing,
  output zsvs_pkg::zsvs_meter_t o_meter
);
  import zsvs_pkg::*;

  localparam int PW = $clog2(STEP_CYC + 1);

  zsvs_chan_t chan_q;
  zsvs_phasor_t neut_q;
  zsvs_cfg_t cfg_q;
  logic [9:0] det_q;
  zsvs_meter_t meter_q;
  zsvs_state_t state_q;
  logic [PW-1:0] pre_q;
  logic [9:0] tenth_q;
  logic alarm_q;
  logic above;
  logic signed [19:0] res_re;
  logic signed [19:0] res_im;
  logic [20:0] res_mag;
  logic [2:0][16:0] ph_mag;
  logic [2:0][17:0] ln_mag;
  logic signed [2:0][16:0] ln_re;
  logic signed [2:0][16:0] ln_im;

  ////////////////////////////////////////////////////////////////////////
  // Decoding used on both phasor parts, and clamping of the detection time
  function automatic logic signed [19:0] resid(
    input logic signed [15:0] a,
    input logic signed [15:0] b,
    input logic signed [15:0] c,
    input logic signed [15:0] n,
    input logic src
  );
    logic signed [19:0] s;
    logic signed [19:0] z;
    s = 20'(a) + 20'(b) + 20'(c);
    // Calculated source leaves only the division remainder
    z = (src == `ZSVS_SRC_MEAS) ? 20'(n) : s / 20'sh3;
    resid = s - 20'sh3 * z;
  endfunction

  function automatic logic signed [16:0] line_comp(
    input logic signed [15:0] cur,
    input logic signed [15:0] nxt,
    input logic signed [15:0] d0,
    input logic signed [15:0] d1,
    input logic delta,
    input logic fill
  );
    line_comp = !delta ? 17'(cur) - 17'(nxt)
              : fill ? -(17'(d0) + 17'(d1))
              : 17'(cur);
  endfunction

  function automatic logic [9:0] clamp_det(input logic [9:0] t);
    clamp_det = (t < `ZSVS_DET_MIN) ? `ZSVS_DET_MIN
              : (t > `ZSVS_DET_MAX) ? `ZSVS_DET_MAX : t;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Input capture
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      chan_q <= '0;
      neut_q <= '0;
    end
    else if (i_sample_valid)
    begin
      chan_q <= i_chan;
      neut_q <= i_neutral_voltage_input;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cfg_q <= '0;
      det_q <= `ZSVS_DET_RST;
    end
    else
    begin
      cfg_q <= i_cfg;
      det_q <= clamp_det(i_residual_detect_time);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Residual and derived voltages
  assign res_re = resid(chan_q[0].re, chan_q[1].re, chan_q[2].re,
                        neut_q.re, cfg_q.zero_seq_source_select);
  assign res_im = resid(chan_q[0].im, chan_q[1].im, chan_q[2].im,
                        neut_q.im, cfg_q.zero_seq_source_select);

  zsvs_mag #(.W(20)) u_res_mag (
    .i_re(res_re),
    .i_im(res_im),
    .o_mag(res_mag)
  );

  for (genvar k = 0; k < 3; k++)
  begin : g_chan
    // Fill only for C-A, and only when two voltages are wired
    assign ln_re[k] = line_comp(chan_q[k].re, chan_q[(k+1)%3].re,
                                chan_q[0].re, chan_q[1].re,
                                cfg_q.input_delta,
                                (k == 2) && cfg_q.voltage_count_select);
    assign ln_im[k] = line_comp(chan_q[k].im, chan_q[(k+1)%3].im,
                                chan_q[0].im, chan_q[1].im,
                                cfg_q.input_delta,
                                (k == 2) && cfg_q.voltage_count_select);
    zsvs_mag #(.W(16)) u_ph_mag (
      .i_re(chan_q[k].re),
      .i_im(chan_q[k].im),
      .o_mag(ph_mag[k])
    );
    zsvs_mag #(.W(17)) u_ln_mag (
      .i_re(ln_re[k]),
      .i_im(ln_im[k]),
      .o_mag(ln_mag[k])
    );
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      meter_q <= '0;
    end
    else
    begin
      meter_q.phase_valid <= !cfg_q.input_delta;
      meter_q.phase <= cfg_q.input_delta ? '0 : ph_mag;
      meter_q.line <= ln_mag;
      meter_q.residual <= res_mag;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Detection timer
  // Registered magnitude adds one cycle of latency to the timer
  assign above = cfg_q.residual_check_use
               && (meter_q.residual > 21'(`ZSVS_THRESH_CNT));

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_q <= ZSVS_IDLE;
      pre_q <= '0;
      tenth_q <= '0;
      alarm_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ZSVS_IDLE:
        begin
          pre_q <= '0;
          tenth_q <= '0;
          alarm_q <= 1'b0;
          if (above)
          begin
            state_q <= ZSVS_TIMING;
          end
        end
        ZSVS_TIMING:
        begin
          if (!above)
          begin
            // Cleared at once, so a fresh rise restarts the full time
            state_q <= ZSVS_IDLE;
            pre_q <= '0;
            tenth_q <= '0;
          end
          else if (pre_q == PW'(STEP_CYC - 1))
          begin
            pre_q <= '0;
            tenth_q <= tenth_q + 10'h001;
            if (tenth_q + 10'h001 >= det_q)
            begin
              state_q <= ZSVS_ALARM;
              alarm_q <= 1'b1;
            end
          end
          else
          begin
            pre_q <= pre_q + PW'(1);
          end
        end
        ZSVS_ALARM:
        begin
          if (!above)
          begin
            state_q <= ZSVS_IDLE;
            alarm_q <= 1'b0;
            tenth_q <= '0;
          end
        end
        default:
        begin
          state_q <= ZSVS_IDLE;
          alarm_q <= 1'b0;
        end
      endcase
    end
  end

  assign o_alarm = alarm_q;
  assign o_timing = state_q[1];
  assign o_meter = meter_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_start;
    $rose(o_timing);
  endsequence
  sequence s_hold8;
    above [*8];
  endsequence

  AST_NO_EARLY_ALARM: assert property (s_start ##0 s_hold8 |-> !o_alarm)
    else $error("alarm raised before detection time");
  AST_ALARM_AT_EXPIRY: assert property ($rose(o_alarm) |->
      $past(tenth_q) == det_q - 10'h001
      && $past(pre_q) == PW'(STEP_CYC - 1))
    else $error("alarm not at timer expiry");
  AST_DET_RANGE: assert property (det_q >= `ZSVS_DET_MIN
      && det_q <= `ZSVS_DET_MAX)
    else $error("detection time out of range");
  AST_USE_OFF: assert property (!cfg_q.residual_check_use |=>
      !o_alarm && !o_timing)
    else $error("alarm or timer active with use off");
  AST_DROP_CLEARS: assert property (!above |=>
      !o_alarm && !o_timing && tenth_q == 10'h000)
    else $error("timer not cleared when residual dropped");
  AST_ALARM_CAUSE: assert property (o_alarm |->
      meter_q.residual > 21'(`ZSVS_THRESH_CNT)
      || $past(above))
    else $error("alarm without residual above threshold");
  AST_CALC_SOURCE: assert property (
      cfg_q.zero_seq_source_select == `ZSVS_SRC_CALC
      |-> res_re <= 20'sh2 && res_re >= -20'sh2)
    else $error("calculated source leaves residual");
  AST_DELTA_FILL: assert property (
      cfg_q.input_delta && cfg_q.voltage_count_select
      |-> ln_re[2] == -(17'(chan_q[0].re) + 17'(chan_q[1].re)))
    else $error("C-A not calculated from A-B and B-C");
  AST_STAR_LINE: assert property (!cfg_q.input_delta
      |-> ln_re[2] == 17'(chan_q[2].re) - 17'(chan_q[0].re))
    else $error("star line voltage wrong");
  AST_DELTA_NO_PHASE: assert property (cfg_q.input_delta |=>
      !o_meter.phase_valid && o_meter.phase == '0)
    else $error("phase values shown in delta mode");

endmodule

// ### common/zsvs_params.svh
/*
  Constants of the zero-sequence voltage supervision block: threshold,
  voltage scaling, timer step and setting limits.
  Assumes voltage samples in counts of 0.1 V and a 10 MHz clock.
*/
`ifndef ZSVS_PARAMS_SVH
`define ZSVS_PARAMS_SVH

// Residual threshold and input scaling
`define ZSVS_THRESH_V 10
`define ZSVS_CNT_PER_V 10
`define ZSVS_THRESH_CNT (`ZSVS_THRESH_V * `ZSVS_CNT_PER_V)

// Clock and detection-time step
`define ZSVS_CLK_PERIOD_NS 100
`define ZSVS_STEP_NS 100000000
`define ZSVS_STEP_CYC (`ZSVS_STEP_NS / `ZSVS_CLK_PERIOD_NS)

// Detection time setting, in 0.1 s steps
`define ZSVS_DET_MIN 10'h00a
`define ZSVS_DET_MAX 10'h3e8
`define ZSVS_DET_RST 10'h00a

// Zero-sequence source encoding
`define ZSVS_SRC_CALC 1'h0
`define ZSVS_SRC_MEAS 1'h1

`endif

// ### common/zsvs_pkg.sv
/*
  Types of the zero-sequence voltage supervision block.
  Assumes phasor components as signed 16-bit counts of 0.1 V.
*/
package zsvs_pkg;

  typedef struct packed {
    logic signed [15:0] re;
    logic signed [15:0] im;
  } zsvs_phasor_t;

  typedef zsvs_phasor_t [2:0] zsvs_chan_t;

  typedef struct packed {
    logic residual_check_use;
    logic zero_seq_source_select;
    logic input_delta;
    logic voltage_count_select;
  } zsvs_cfg_t;

  typedef struct packed {
    logic phase_valid;
    logic [2:0][16:0] phase;
    logic [2:0][17:0] line;
    logic [20:0] residual;
  } zsvs_meter_t;

  typedef enum logic [2:0] {
    ZSVS_IDLE   = 3'h1,
    ZSVS_TIMING = 3'h2,
    ZSVS_ALARM  = 3'h4
  } zsvs_state_t;

endpackage

// ### design/zsvs_mag.sv
/*
  Phasor magnitude estimate, max plus half of min of the absolute parts.
  Assumes signed components; result is unsigned and one bit wider.
*/
`timescale 1ns/10ps
module zsvs_mag #(
  parameter int W = 16
) (
  // Phasor in
  input wire logic signed [W-1:0] i_re,
  input wire logic signed [W-1:0] i_im,
  // Magnitude out
  output logic [W:0] o_mag
);

  logic [W-1:0] abs_re;
  logic [W-1:0] abs_im;

  // Negating the most negative value still fits W unsigned bits
  assign abs_re = i_re[W-1] ? W'(-i_re) : W'(i_re);
  assign abs_im = i_im[W-1] ? W'(-i_im) : W'(i_im);

  always_comb
  begin
    if (abs_re >= abs_im)
    begin
      o_mag = {1'b0, abs_re} + {2'b00, abs_im[W-1:1]};
    end
    else
    begin
      o_mag = {1'b0, abs_im} + {2'b00, abs_re[W-1:1]};
    end
  end

endmodule

// ### testbench/zsvs_src.sv
/*
  Measurement front end model: drives one phasor sample per clock.
  Assumes real-only phasors in counts of 0.1 V, set by the testbench.
*/
`timescale 1ns/10ps
module zsvs_src (
  // Clock
  input wire logic i_ref_clk,
  // Wanted values
  input wire logic signed [15:0] i_va,
  input wire logic signed [15:0] i_vb,
  input wire logic signed [15:0] i_vc,
  input wire logic signed [15:0] i_vn,
  input wire logic i_drop_c,
  // Samples
  output logic o_valid,
  output zsvs_pkg::zsvs_chan_t o_chan,
  output zsvs_pkg::zsvs_phasor_t o_neutral
);
  import zsvs_pkg::*;

  logic [15:0] junk_q;

  initial
  begin
    junk_q = 16'h0000;
    o_valid = 1'b0;
    o_chan = '0;
    o_neutral = '0;
  end

  // Wanted values taken at the edge, outputs moved just after it,
  // so the bench's own updates never race this model
  always @(posedge i_ref_clk)
  begin
    junk_q <= #10 junk_q + 16'h1357;
    o_valid <= #10 1'b1;
    o_chan[0] <= #10 {i_va, 16'h0000};
    o_chan[1] <= #10 {i_vb, 16'h0000};
    // Unwired channel shows a moving pattern, never a stale value
    o_chan[2] <= #10 i_drop_c ? {junk_q, ~junk_q} : {i_vc, 16'h0000};
    o_neutral <= #10 {i_vn, 16'h0000};
  end
endmodule

// ### testbench/tb.sv
/*
  Self-checking bench of the zero-sequence supervision block.
  Assumes a short timer step so that alarms come within tens of cycles.
*/
`timescale 1ns/10ps
module tb;
  import zsvs_pkg::*;

  logic i_ref_clk = 1'b0;
  logic i_nrst = 1'b0;
  zsvs_cfg_t cfg = '0;
  logic [9:0] det = 10'h00a;
  logic signed [15:0] va = 0, vb = 0, vc = 0, vn = 0;
  logic drop_c = 1'b0;
  logic valid;
  zsvs_chan_t chan;
  zsvs_phasor_t neut;
  logic o_alarm, o_timing;
  zsvs_meter_t meter;
  int fail_count = 0;
  int samples_checked = 0;

  always #50 i_ref_clk = ~i_ref_clk;

  zsvs_src i_src (.i_ref_clk(i_ref_clk), .i_va(va), .i_vb(vb), .i_vc(vc),
    .i_vn(vn), .i_drop_c(drop_c), .o_valid(valid), .o_chan(chan),
    .o_neutral(neut));

  zsvs_top #(.STEP_CYC(4)) i_dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_cfg(cfg), .i_residual_detect_time(det), .i_sample_valid(valid),
    .i_chan(chan), .i_neutral_voltage_input(neut), .o_alarm(o_alarm),
    .o_timing(o_timing), .o_meter(meter));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    if (fail_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #10;
  endtask

  task setv(input logic signed [15:0] a, b, c, n,
            input logic u, s, d, t);
    va = a;
    vb = b;
    vc = c;
    vn = n;
    cfg.residual_check_use = u;
    cfg.zero_seq_source_select = s;
    cfg.input_delta = d;
    cfg.voltage_count_select = t;
    // Unused C-A channel only in delta with two voltages
    drop_c = d & t;
    cyc(5);
  endtask

  task meter_chk(input logic pv, input logic [31:0] p0, p1, p2, l0, l1, l2);
    check(meter.phase_valid, pv);
    check(meter.phase[0], p0);
    check(meter.phase[1], p1);
    check(meter.phase[2], p2);
    check(meter.line[0], l0);
    check(meter.line[1], l1);
    check(meter.line[2], l2);
  endtask

  // Bounded wait on a flag, then a compare
  task wait_hi(input int lim, input bit alm);
    int k;
    k = 0;
    while ((alm ? o_alarm : o_timing) !== 1'b1 && k < lim)
    begin
      cyc(1);
      k++;
    end
    check(alm ? o_alarm : o_timing, 1'b1);
  endtask

  initial
  begin
    cyc(2);
    i_nrst = 1'b1;
    check({o_alarm, o_timing, meter.residual}, 32'h0);
    // Star inputs, measured source, use off
    setv(1001, 200, -300, 0, 1'b0, 1'b1, 1'b0, 1'b0);
    meter_chk(1'b1, 1001, 200, 300, 801, 500, 1301);
    check(meter.residual, 901);
    cyc(60);
    check({o_alarm, o_timing}, 2'h0);
    // Two-voltage selection has no effect in star
    setv(1001, 200, -300, 0, 1'b0, 1'b1, 1'b0, 1'b1);
    meter_chk(1'b1, 1001, 200, 300, 801, 500, 1301);
    setv(1001, 200, -300, 0, 1'b0, 1'b0, 1'b0, 1'b0);
    check(meter.residual, 1);
    // Residual exactly at threshold does not start the timer
    setv(1001, 200, -300, 267, 1'b1, 1'b1, 1'b0, 1'b0);
    check(meter.residual, 100);
    cyc(20);
    check(o_timing, 1'b0);
    // Setting below range is held at 1.0 s
    det = 10'h005;
    setv(1001, 200, -300, 0, 1'b1, 1'b1, 1'b0, 1'b0);
    wait_hi(10, 1'b0);
    cyc(38);
    check(o_alarm, 1'b0);
    wait_hi(4, 1'b1);
    check(o_timing, 1'b0);
    setv(1001, 200, -300, 300, 1'b1, 1'b1, 1'b0, 1'b0);
    check({o_alarm, o_timing}, 2'h0);
    // Drop mid-count restarts the full 1.1 s
    det = 10'h00b;
    setv(1001, 200, -300, 0, 1'b1, 1'b1, 1'b0, 1'b0);
    cyc(20);
    setv(1001, 200, -300, 300, 1'b1, 1'b1, 1'b0, 1'b0);
    check({o_alarm, o_timing}, 2'h0);
    setv(1001, 200, -300, 0, 1'b1, 1'b1, 1'b0, 1'b0);
    cyc(42);
    check(o_alarm, 1'b0);
    wait_hi(2, 1'b1);
    cfg.residual_check_use = 1'b0;
    cyc(2);
    check({o_alarm, o_timing}, 2'h0);
    // Delta inputs with the use setting off
    setv(800, 500, -1300, 0, 1'b0, 1'b1, 1'b1, 1'b0);
    meter_chk(1'b0, 0, 0, 0, 800, 500, 1300);
    setv(800, 500, 0, 0, 1'b0, 1'b1, 1'b1, 1'b1);
    meter_chk(1'b0, 0, 0, 0, 800, 500, 1300);
    print_verdict();
  end

  initial
  begin
    #200000;
    fail_count++;
    print_verdict();
  end
endmodule
